// *** tx_align_params.svh ***
`ifndef TX_ALIGN_PARAMS_SVH
`define TX_ALIGN_PARAMS_SVH

// Register byte offsets on the AXI4-Lite port.
`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_CHAR_A 8'h10
`define OFS_CHAR_B 8'h14

// Control register width and reset value.
`define CTRL_WIDTH 6
`define CTRL_RESET 6'h00

// Interrupt status layout: parity events low, buffer faults above.
`define IRQ_BITS 4
`define IRQ_PERR_LSB 0
`define IRQ_FAULT_LSB 2

// Substitute for a character with bad parity (special code C0.7).
`define SUBST_BYTE 8'hE0
`define SUBST_CTL 2'h0

// Control codes used when the encoder is enabled.
`define DATA_CTL 2'h0
`define WS_CTL 2'h3
`define CODING_BYPASS 2'h0

// AXI response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** tx_align_pkg.sv ***
package tx_align_pkg;

    // Clock source for the input registers; code 2'b11 is not legal.
    typedef enum logic [1:0] {
        CLK_SRC_REF = 2'b00,
        CLK_SRC_OWN = 2'b01,
        CLK_SRC_CHA = 2'b10
    } clk_src_t;

    // Phase-align buffer state shared by both channels.
    typedef enum logic [1:0] {
        ALIGN_BYPASS = 2'b00,
        ALIGN_RECENTER = 2'b01,
        ALIGN_RUN = 2'b10
    } align_state_t;

    // Character handed to the encoder or shifter.
    typedef struct packed {
        logic word_sync;
        logic special;
        logic [9:0] data;
    } tx_char_t;

    // Captured character with its parity verdict.
    typedef struct packed {
        tx_char_t ch;
        logic perr;
    } cap_t;

    // All pins that cross into the aclk domain.
    typedef struct packed {
        logic ref_clk;
        logic [1:0] ch_clk;
        logic align_rst_n;
        logic scs;
        logic [1:0] par;
        logic [1:0][1:0] ctl;
        logic [1:0][7:0] tx_byte;
    } pins_t;

    // Control register fields.
    typedef struct packed {
        logic parity_control;
        logic half_rate_select;
        clk_src_t clock_source_select;
        logic [1:0] coding_select;
    } ctrl_t;

endpackage : tx_align_pkg

// *** tx_input_capture_phase_align.sv ***
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "tx_align_params.svh"
// Overview of operation
// - Encoder on: data byte is the sent character.
// - Encoder bypassed: byte plus control form ten bits.
// - Phase reset low lets buffers re-centre.
// - Phase reset high keeps phase fixed, normal run.
// - Half-rate mode: phase reset only clears faults.
// - Re-centring may insert or drop characters.
// - Reference full-rate mode ignores phase reset.
// - Half-rate reference samples on both edges.
// - Special select with control 3 marks sync, not special.
// - Independent clocks: special select on channel A.
// - Parity enabled: odd parity checked per character.
// - Parity error: one-tick flag, C0.7 substituted.
// - Buffer slip fault sticks until sync or reset.
// - Clock select picks reference, own or A clock.
module tx_input_capture_phase_align
    import tx_align_pkg::*;
#(
    parameter int ALIGN_DEPTH = 4
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic reference_clock,
    input wire logic [1:0] per_channel_tx_clock,
    input wire logic tx_align_reset_n,
    input wire logic special_char_select,
    input wire logic [1:0][7:0] tx_byte_in,
    input wire logic [1:0][1:0] tx_control_in,
    input wire logic odd_parity_in_a,
    input wire logic odd_parity_in_b,
    output tx_char_t [1:0] tx_char_out,
    output logic [1:0] tx_char_valid,
    output logic [1:0] tx_fault_out,
    output logic irq
);

    localparam int AW = $clog2(ALIGN_DEPTH);
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] DEPTH_P = PW'(ALIGN_DEPTH);
    localparam logic [PW-1:0] HALF_P = PW'(ALIGN_DEPTH / 2);

    // The pointer arithmetic wraps on a power of two and centring needs two slots each way.
    if ((ALIGN_DEPTH < 4) || ((ALIGN_DEPTH & (ALIGN_DEPTH - 1)) != 0))
    begin : g_bad_depth
        $error("ALIGN_DEPTH must be a power of two, at least 4.");
    end

    typedef struct packed {
        pins_t s1, s2, s3, filt;
        ctrl_t ctrl;
        align_state_t align;
        logic [1:0][PW-1:0] wp, rp;
        cap_t [1:0][ALIGN_DEPTH-1:0] buf_mem;
        logic [1:0] ch_prev, buf_fault, perr_hold, fault_out, char_valid;
        tx_char_t [1:0] char_out;
        logic [`IRQ_BITS-1:0] irq_stat, irq_mask;
        logic irq, aw_held, w_held, ref_prev, scs_cap;
        logic [`ADDR_W-1:0] waddr;
        logic [31:0] wdat, rdata;
        logic [3:0] wstb;
        logic awready, wready, bvalid, arready, rvalid;
        logic [1:0] bresp, rresp;
    } state_t;

    state_t st_reg;
    state_t st_next;

    pins_t pins;
    logic ref_rise, ref_fall, src_ref, half, bypass, char_tick;
    logic rst_low_sample, rst_clear, coding_en, scs_used;
    logic [1:0] ch_rise, wr_tick, emit, ovf, unf, ws_out;
    cap_t [1:0] cap, sel;
    logic [1:0][PW-1:0] occ;
    logic [`IRQ_BITS-1:0] irq_set, irq_clr;

    // Gather the pins so they cross the clock boundary as one bundle.
    assign pins = '{ref_clk: reference_clock, ch_clk: per_channel_tx_clock,
                    align_rst_n: tx_align_reset_n, scs: special_char_select,
                    par: {odd_parity_in_b, odd_parity_in_a}, ctl: tx_control_in,
                    tx_byte: tx_byte_in};

    // Parity failures force a visible bad character at the far end.
    function automatic tx_char_t emit_char(input cap_t c);
        tx_char_t r;
        r = c.ch;
        if (c.perr)
        begin
            r.word_sync = 1'b0;
            r.special = 1'b1;
            r.data = {`SUBST_CTL, `SUBST_BYTE};
        end
        return r;
    endfunction : emit_char

    // Next-state logic for the whole block.
    always_comb
    begin
        st_next = st_reg;
        // Input pins pass three stages; a level counts once stages two and three agree.
        st_next.s1 = pins;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.filt = pins_t'((st_reg.s2 & st_reg.s3) | (st_reg.filt & (st_reg.s2 ^ st_reg.s3)));
        st_next.ref_prev = st_reg.filt.ref_clk;
        st_next.ch_prev = st_reg.filt.ch_clk;
        ref_rise = st_reg.filt.ref_clk & ~st_reg.ref_prev;
        ref_fall = ~st_reg.filt.ref_clk & st_reg.ref_prev;
        ch_rise = st_reg.filt.ch_clk & ~st_reg.ch_prev;

        // Half rate is only legal with the reference source; otherwise it is ignored.
        src_ref = (st_reg.ctrl.clock_source_select != CLK_SRC_OWN)
                  && (st_reg.ctrl.clock_source_select != CLK_SRC_CHA);
        half = src_ref & st_reg.ctrl.half_rate_select;
        bypass = src_ref & ~st_reg.ctrl.half_rate_select;
        char_tick = ref_rise | (half & ref_fall);
        rst_low_sample = ref_rise & ~st_reg.filt.align_rst_n;
        rst_clear = rst_low_sample & ~bypass;
        coding_en = st_reg.ctrl.coding_select != `CODING_BYPASS;

        if (st_reg.ctrl.clock_source_select == CLK_SRC_OWN && ch_rise[0])
            st_next.scs_cap = st_reg.filt.scs;
        scs_used = (st_reg.ctrl.clock_source_select == CLK_SRC_OWN && !ch_rise[0])
                   ? st_reg.scs_cap : st_reg.filt.scs;

        irq_set = '0;
        for (int c = 0; c < 2; c++)
        begin
            if (src_ref)
                wr_tick[c] = char_tick;
            else if (st_reg.ctrl.clock_source_select == CLK_SRC_OWN)
                wr_tick[c] = ch_rise[c];
            else
                wr_tick[c] = ch_rise[0];
            cap[c].ch.data = {st_reg.filt.ctl[c], st_reg.filt.tx_byte[c]};
            cap[c].ch.word_sync = coding_en & scs_used & (st_reg.filt.ctl[c] == `WS_CTL);
            cap[c].ch.special = coding_en & (st_reg.filt.ctl[c] != `DATA_CTL)
                                & ~cap[c].ch.word_sync;
            cap[c].perr = st_reg.ctrl.parity_control
                          & ~(^{st_reg.filt.par[c], st_reg.filt.tx_byte[c]});

            occ[c] = st_reg.wp[c] - st_reg.rp[c];
            sel[c] = bypass ? cap[c] : st_reg.buf_mem[c][st_reg.rp[c][AW-1:0]];
            emit[c] = 1'b0;
            ovf[c] = 1'b0;
            unf[c] = 1'b0;
            if (bypass)
                emit[c] = char_tick;
            else
            begin
                if (wr_tick[c])
                begin
                    if (occ[c] == DEPTH_P)
                        ovf[c] = (st_reg.align == ALIGN_RUN); // Slips while centring are allowed.
                    else
                    begin
                        st_next.buf_mem[c][st_reg.wp[c][AW-1:0]] = cap[c];
                        st_next.wp[c] = st_reg.wp[c] + PW'(1);
                    end
                end
                if (char_tick && st_reg.align == ALIGN_RUN)
                begin
                    if (occ[c] == '0)
                        unf[c] = 1'b1;
                    else
                    begin
                        emit[c] = 1'b1;
                        st_next.rp[c] = st_reg.rp[c] + PW'(1);
                    end
                end
                if (char_tick && st_reg.align == ALIGN_RECENTER)
                    st_next.rp[c] = st_next.wp[c] - HALF_P;
            end

            if (emit[c])
                st_next.char_out[c] = emit_char(sel[c]);
            if (char_tick)
                st_next.perr_hold[c] = emit[c] & sel[c].perr;
            ws_out[c] = emit[c] & sel[c].ch.word_sync & ~sel[c].perr;
            st_next.buf_fault[c] = ovf[c] | unf[c]
                                   | (st_reg.buf_fault[c] & ~(ws_out[c] | rst_clear));
            st_next.fault_out[c] = st_next.perr_hold[c] | st_next.buf_fault[c];
            st_next.char_valid[c] = emit[c];
            irq_set[`IRQ_PERR_LSB + c] = emit[c] & sel[c].perr;
            irq_set[`IRQ_FAULT_LSB + c] = ovf[c] | unf[c];
        end

        // Shared alignment state; the first entry from bypass centres the buffers.
        unique case (st_reg.align)
            ALIGN_BYPASS:
                if (!bypass)
                    st_next.align = ALIGN_RECENTER;
            ALIGN_RECENTER:
                if (bypass)
                    st_next.align = ALIGN_BYPASS;
                else if (ref_rise && (half || st_reg.filt.align_rst_n))
                    st_next.align = ALIGN_RUN;
            ALIGN_RUN:
                if (bypass)
                    st_next.align = ALIGN_BYPASS;
                else if (rst_low_sample && !half)
                    st_next.align = ALIGN_RECENTER;
            default:
                st_next.align = ALIGN_BYPASS;
        endcase

        // Write channel: address and data are taken in either order, then answered.
        irq_clr = '0;
        if (st_reg.bvalid && bready)
            st_next.bvalid = 1'b0;
        if (awvalid && st_reg.awready)
        begin
            st_next.aw_held = 1'b1;
            st_next.waddr = awaddr;
        end
        if (wvalid && st_reg.wready)
        begin
            st_next.w_held = 1'b1;
            st_next.wdat = wdata;
            st_next.wstb = wstrb;
        end
        if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
        begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `RESP_OKAY;
            unique case ({st_reg.waddr[`ADDR_W-1:2], 2'b00})
                `OFS_CTRL:
                    if (st_reg.wstb[0])
                        st_next.ctrl = ctrl_t'(st_reg.wdat[`CTRL_WIDTH-1:0]);
                `OFS_IRQ_STAT:
                    if (st_reg.wstb[0])
                        irq_clr = st_reg.wdat[`IRQ_BITS-1:0];
                `OFS_IRQ_MASK:
                    if (st_reg.wstb[0])
                        st_next.irq_mask = st_reg.wdat[`IRQ_BITS-1:0];
                `OFS_STATUS, `OFS_CHAR_A, `OFS_CHAR_B: ;
                default:
                    st_next.bresp = `RESP_SLVERR;
            endcase
        end
        st_next.awready = ~st_next.aw_held & ~st_next.bvalid;
        st_next.wready = ~st_next.w_held & ~st_next.bvalid;

        // Sticky events: a new event in the clearing cycle survives the clear.
        st_next.irq_stat = irq_set | (st_reg.irq_stat & ~irq_clr);
        st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

        // Read channel answers one cycle after the address is taken.
        if (st_reg.rvalid && rready)
            st_next.rvalid = 1'b0;
        if (arvalid && st_reg.arready)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp = `RESP_OKAY;
            unique case ({araddr[`ADDR_W-1:2], 2'b00})
                `OFS_CTRL: st_next.rdata = 32'(st_reg.ctrl);
                `OFS_STATUS: st_next.rdata = 32'({st_reg.fault_out, st_reg.buf_fault, st_reg.align});
                `OFS_IRQ_STAT: st_next.rdata = 32'(st_reg.irq_stat);
                `OFS_IRQ_MASK: st_next.rdata = 32'(st_reg.irq_mask);
                `OFS_CHAR_A: st_next.rdata = 32'(st_reg.char_out[0]);
                `OFS_CHAR_B: st_next.rdata = 32'(st_reg.char_out[1]);
                default:
                begin
                    st_next.rdata = '0;
                    st_next.rresp = `RESP_SLVERR;
                end
            endcase
        end
        st_next.arready = ~st_next.rvalid;
    end

    // Single state register with synchronous reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= '0;
            st_reg.ctrl <= ctrl_t'(`CTRL_RESET);
        end
        else
            st_reg <= st_next;
    end

    // All outputs come straight from state flip-flops.
    assign {awready, wready, arready} = {st_reg.awready, st_reg.wready, st_reg.arready};
    assign {bvalid, bresp, rvalid, rresp} = {st_reg.bvalid, st_reg.bresp, st_reg.rvalid,
        st_reg.rresp};
    assign rdata = st_reg.rdata;
    assign tx_char_out = st_reg.char_out;
    assign {tx_char_valid, tx_fault_out, irq} = {st_reg.char_valid, st_reg.fault_out, st_reg.irq};

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Checks on the capture, alignment and fault behaviour.
    AST_BYPASS_EMIT: assert property (bypass && char_tick |=> tx_char_valid[0])
        else $error("Bypass tick did not emit a character.");
    AST_BYPASS_STATE: assert property (bypass |=> st_reg.align == ALIGN_BYPASS)
        else $error("Phase reset acted while the buffer is bypassed.");
    AST_RECENTER_OCC: assert property (st_reg.align == ALIGN_RECENTER && char_tick && !bypass
        |=> occ[0] == HALF_P)
        else $error("Re-centring did not leave the buffer half full.");
    AST_RUN_HOLD: assert property (st_reg.align == ALIGN_RUN && !rst_low_sample && !bypass
        |=> st_reg.align == ALIGN_RUN)
        else $error("Alignment left run without a phase reset.");
    AST_HALF_CLEAR: assert property (st_reg.align == ALIGN_RUN && half && rst_low_sample
        && !ovf[0] && !unf[0] |=> st_reg.align == ALIGN_RUN && !st_reg.buf_fault[0])
        else $error("Half-rate phase reset did more than clear faults.");
    AST_HALF_FALL: assert property (half && ref_fall && st_reg.align == ALIGN_RUN
        && occ[0] != '0 |=> tx_char_valid[0])
        else $error("Falling reference edge did not move a character.");
    AST_PARITY_SUBST: assert property (tx_char_valid[0] && st_reg.perr_hold[0]
        |-> tx_char_out[0].data == {`SUBST_CTL, `SUBST_BYTE} && tx_fault_out[0])
        else $error("Parity error not substituted and flagged.");
    AST_PARITY_OFF: assert property (bypass && !st_reg.ctrl.parity_control && char_tick
        |=> !st_reg.perr_hold[0])
        else $error("Parity error reported with checking disabled.");
    AST_FAULT_STICKY: assert property (st_reg.buf_fault[0] && !ws_out[0] && !rst_clear
        |=> st_reg.buf_fault[0] ##0 tx_fault_out[0])
        else $error("Buffer fault dropped without sync or reset.");
    AST_IRQ_LEVEL: assert property (irq == |(st_reg.irq_stat & st_reg.irq_mask))
        else $error("Interrupt output disagrees with status and mask.");
    AST_WRITE_RESP: assert property (awvalid && awready && wvalid && wready
        |-> ##[1:2] bvalid)
        else $error("Write response late.");

    COV_PARITY: cover property (st_reg.perr_hold[0] && tx_char_valid[0]);
    COV_SLIP: cover property ($rose(st_reg.buf_fault[1]));
    COV_SYNC_CLEAR: cover property (st_reg.buf_fault[0] && ws_out[0]);
    COV_RECENTER: cover property (st_reg.align == ALIGN_RECENTER ##1 st_reg.align == ALIGN_RUN);

endmodule : tx_input_capture_phase_align

// *** tx_host_model.sv ***
`timescale 1ns/1ps
// Host logic that feeds the parallel transmit pins of the block.
module tx_host_model (
    input wire logic aclk,
    output logic reference_clock,
    output logic [1:0] per_channel_tx_clock,
    output logic tx_align_reset_n,
    output logic special_char_select,
    output logic [1:0][7:0] tx_byte_in,
    output logic [1:0][1:0] tx_control_in,
    output logic odd_parity_in_a,
    output logic odd_parity_in_b
);
    real ch_half = 100.0;

    // The reference clock runs free so the transmit synthesiser stays locked.
    initial
    begin
        reference_clock = 1'b0;
        forever #100 reference_clock = ~reference_clock;
    end

    // Channel clocks can be sped up to force a buffer slip.
    initial
    begin
        per_channel_tx_clock = 2'b00;
        forever #(ch_half) per_channel_tx_clock = ~per_channel_tx_clock;
    end

    // Pins idle at a character with good parity.
    initial
    begin
        tx_align_reset_n = 1'b1;
        special_char_select = 1'b0;
        tx_byte_in = '0;
        tx_control_in = '0;
        odd_parity_in_a = 1'b1;
        odd_parity_in_b = 1'b1;
    end

    // Pins change away from the capture edges and hold for whole periods.
    task automatic put(input logic [7:0] b, input logic [1:0] c, input logic bad,
        input logic s, input int edges);
        @(negedge reference_clock);
        @(posedge aclk);
        tx_byte_in <= {b, b};
        tx_control_in <= {c, c};
        special_char_select <= s;
        odd_parity_in_a <= ~(^b) ^ bad;
        odd_parity_in_b <= ~(^b) ^ bad;
        repeat (edges) @(posedge reference_clock);
    endtask : put

    task automatic align_reset();
        @(negedge reference_clock);
        @(posedge aclk);
        tx_align_reset_n <= 1'b0;
        repeat (2) @(posedge reference_clock);
        @(negedge reference_clock);
        @(posedge aclk);
        tx_align_reset_n <= 1'b1;
    endtask : align_reset
endmodule : tx_host_model

// *** tb_tx_input_capture_phase_align.sv ***
`timescale 1ns/1ps
`include "tx_align_params.svh"
module tb_tx_input_capture_phase_align;
    import tx_align_pkg::*;
    typedef struct packed {
        logic [5:0] ctrl;
        logic [7:0] b;
        logic [1:0] c;
        logic bad;
        logic s;
        logic [11:0] ch;
        logic flt;
    } row_t;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, tx_char_valid, tx_fault_out, pch;
    logic refc, arst_n, scs, opa, opb;
    logic [1:0][7:0] tb_byte;
    logic [1:0][1:0] tb_ctl;
    tx_char_t [1:0] tx_char_out;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    // Bypass rows first so mode changes into buffered modes come last.
    row_t rows [9] = '{
        '{6'h00, 8'hA5, 2'h2, 1'b0, 1'b0, 12'h2A5, 1'b0},
        '{6'h01, 8'h3C, 2'h0, 1'b0, 1'b0, 12'h03C, 1'b0},
        '{6'h01, 8'hBC, 2'h1, 1'b0, 1'b0, 12'h5BC, 1'b0},
        '{6'h01, 8'h00, 2'h3, 1'b0, 1'b1, 12'hB00, 1'b0},
        '{6'h21, 8'h55, 2'h0, 1'b1, 1'b0, 12'h4E0, 1'b1},
        '{6'h20, 8'h55, 2'h1, 1'b0, 1'b0, 12'h155, 1'b0},
        '{6'h04, 8'h81, 2'h0, 1'b0, 1'b0, 12'h081, 1'b0},
        '{6'h08, 8'h7E, 2'h2, 1'b0, 1'b0, 12'h27E, 1'b0},
        '{6'h10, 8'h99, 2'h0, 1'b0, 1'b0, 12'h099, 1'b0}};

    tx_input_capture_phase_align #(.ALIGN_DEPTH(4)) uut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .reference_clock(refc), .per_channel_tx_clock(pch),
        .tx_align_reset_n(arst_n), .special_char_select(scs), .tx_byte_in(tb_byte),
        .tx_control_in(tb_ctl), .odd_parity_in_a(opa), .odd_parity_in_b(opb),
        .tx_char_out(tx_char_out), .tx_char_valid(tx_char_valid),
        .tx_fault_out(tx_fault_out), .irq(irq));
    tx_host_model host (.aclk(aclk), .reference_clock(refc), .per_channel_tx_clock(pch),
        .tx_align_reset_n(arst_n), .special_char_select(scs), .tx_byte_in(tb_byte),
        .tx_control_in(tb_ctl), .odd_parity_in_a(opa), .odd_parity_in_b(opb));

    // System clock, 25 ns period.
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Hang guard: the whole run needs under two thousand cycles.
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d, n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    // Address and data go out together; each is dropped once taken.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (!(bvalid === 1'b1));
        rs = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (!(rvalid === 1'b1));
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_read

    // Values sampled here are those settled before the edge.
    task automatic wait_char();
        @(posedge aclk);
        while (tx_char_valid[0] !== 1'b1)
            @(posedge aclk);
    endtask : wait_char

    initial
    begin
        aresetn = 1'b0;
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        check("valid in reset", tx_char_valid, 0);
        check("irq in reset", irq, 0);
        aresetn <= 1'b1;
        axi_read(`OFS_CTRL, d, r);
        check("ctrl reset", d, 0);
        // Each row pulses phase reset after the mode change; that re-centres the buffers in the full-rate buffered modes only.
        foreach (rows[i])
        begin
            axi_write(`OFS_CTRL, 32'(rows[i].ctrl), r);
            host.align_reset();
            host.put(rows[i].b, rows[i].c, rows[i].bad, rows[i].s, 6);
            wait_char();
            check("char a", tx_char_out[0], rows[i].ch);
            check("char b", tx_char_out[1], rows[i].ch);
            check("fault a", tx_fault_out[0], rows[i].flt);
        end
        // Parity events are latched but masked until enabled.
        check("irq masked", irq, 0);
        axi_read(`OFS_IRQ_STAT, d, r);
        check("parity events", d & 32'h0000_0003, 32'h0000_0003);
        axi_write(`OFS_IRQ_MASK, 32'h0000_0001, r);
        check("irq on", irq, 1);
        axi_write(`OFS_IRQ_STAT, 32'h0000_0001, r);
        check("irq cleared", irq, 0);
        // Fast channel clocks overflow the buffer; the fault sticks.
        axi_write(`OFS_CTRL, 32'h0000_0004, r);
        host.align_reset();
        host.ch_half = 60.0;
        repeat (40) @(posedge refc);
        host.ch_half = 100.0;
        repeat (10) @(posedge refc);
        @(posedge aclk);
        check("slip fault", tx_fault_out[0], 1);
        host.align_reset();
        repeat (6) @(posedge refc);
        @(posedge aclk);
        check("fault cleared", tx_fault_out[0], 0);
        axi_read(`OFS_STATUS, d, r);
        check("align run", d & 32'h0000_0003, 2);
        // A word sync character also ends a stuck slip fault.
        host.ch_half = 60.0;
        repeat (20) @(posedge refc);
        host.ch_half = 100.0;
        axi_write(`OFS_CTRL, 32'h0000_0005, r);
        check("slip again", tx_fault_out[0], 1);
        host.put(8'h00, 2'h3, 1'b0, 1'b1, 6);
        wait_char();
        check("sync char", tx_char_out[0], 12'hB00);
        check("sync clears fault", tx_fault_out[0], 0);
        // Phase reset in full-rate reference mode leaves the buffer bypassed.
        axi_write(`OFS_CTRL, 32'h0000_0000, r);
        host.align_reset();
        axi_read(`OFS_STATUS, d, r);
        check("align bypass", d & 32'h0000_0003, 0);
        axi_read(8'h20, d, r);
        check("unmapped read", {d[29:0], r}, 2);
        axi_write(8'h20, 32'h0000_0001, r);
        check("unmapped write", r, 2);
        print_verdict();
    end
endmodule : tb_tx_input_capture_phase_align
